// file: hdl/smbap_pkg.sv
// constants, types and state codes of the serial bus slave front end
// assumes a 125 MHz system clock and bus pins already synchronous to it
// How it works
// - strap high: answer fixed address 0101110
// - strap low: second strap picks 0101100/0101101
// - latch address at eighth rise of match
// - start, then shift address msb first, direction
// - matching address is acknowledged before ninth clock
// - mismatched slave idles until next start
// - direction 0 writes, 1 reads
// - nine clocks per byte, data changes low
// - data rising while clock high is stop
// - direction fixed until a new start
// - one or two write bytes, one read
// - first write byte loads pointer, second stores
// - pointer-only write changes no data register
// - read returns register the pointer selects
// - repeated start begins a new operation
// - send, receive and read byte supported
// - active-low alert output for limit events
// - release bus after 35 ms idle unless disabled
// - alert response address returns own address
package smbap_pkg;

  localparam logic [6:0] FIXED_ADDR   = 7'h2e;
  localparam logic [6:0] STRAP_ADDR0  = 7'h2c;
  localparam logic [6:0] STRAP_ADDR1  = 7'h2d;
  localparam logic [6:0] ALERT_RESP   = 7'h0c;
  localparam logic [7:0] PTR_RESET    = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ADDR_LOCK_BIT = 4'h7;
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         BUS_TIMEOUT_MS = 35;
  localparam int         BUS_TIMEOUT_CYC =
    BUS_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int         TMO_W        = 23;
  localparam int         FIFO_DEPTH   = 8;

  // byte position inside one operation
  localparam logic [1:0] POS_ADDR = 2'h0;
  localparam logic [1:0] POS_PTR  = 2'h1;
  localparam logic [1:0] POS_DATA = 2'h2;
  localparam logic [1:0] POS_OVER = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK  = 3'b010,
    ST_SEND = 3'b011,
    ST_MACK = 3'b100,
    ST_WAIT = 3'b101
  } smbap_state_e;

  // one register write handed to the register file
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
  } smbap_wr_s;

endpackage

// file: hdl/smbap_slave.sv
// bus slave: address select, start/stop, pointer, byte write/read path
// assumes scl/sda inputs already synchronous to clk; pins are open drain
module smbap_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  wire              do_push = in_valid && in_ready;
  wire              do_pop  = out_valid && out_ready;

  // honest flags from the fill count
  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_idx];

  // pointers wrap at the depth
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
      end
      if (do_pop) begin
        rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // storage
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_idx] <= in_data;
    end
  end
endmodule

module smbap_slave
  import smbap_pkg::*;
#(
  parameter int TIMEOUT_CYC = BUS_TIMEOUT_CYC,
  parameter int DEPTH       = FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       address_select_strap,
  input  wire logic       address_pick_strap,
  input  wire logic       bus_timeout_disable,
  input  wire logic       alert_req,
  output logic            alert_n,
  output logic [7:0]      rd_index,
  input  wire logic [7:0] rd_data,
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output smbap_wr_s       wr_req,
  output logic [6:0]      own_addr
);
  smbap_state_e     st;
  logic             scl_q;
  logic             sda_q;
  logic [3:0]       cnt;
  logic [7:0]       sr;
  logic [7:0]       tx;
  logic [1:0]       pos;
  logic             is_read;
  logic             locked;
  logic [TMO_W-1:0] tmo_cnt;
  logic             f_valid;
  logic             f_ready;
  smbap_wr_s        f_data;
  smbap_wr_s        push_data;

  // bus events seen from the sampled pins
  wire scl_rise  = scl_in && !scl_q;
  wire scl_fall  = !scl_in && scl_q;
  wire start_det = scl_in && scl_q && sda_q && !sda_in;
  wire stop_det  = scl_in && scl_q && !sda_q && sda_in;
  wire activity  = scl_in != scl_q || sda_in != sda_q;

  // address chosen by the straps
  wire [6:0] strap_addr = address_select_strap ? FIXED_ADDR
                        : address_pick_strap ? STRAP_ADDR1
                        : STRAP_ADDR0;
  wire addr_hit = sr[7:1] == own_addr;
  wire ara_hit  = sr[7:1] == ALERT_RESP && sr[0] && !alert_n;
  wire byte_end = st == ST_RECV && cnt == BITS_PER_BYTE && !scl_in;
  wire push     = byte_end && pos == POS_DATA && f_ready;
  wire tmo_hit  = tmo_cnt == TMO_W'(TIMEOUT_CYC - 1) && !bus_timeout_disable;
  wire lock_now = st == ST_RECV && pos == POS_ADDR && scl_rise
                  && cnt == ADDR_LOCK_BIT && sr[6:0] == own_addr;

  assign push_data.index = rd_index;
  assign push_data.data  = sr;
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;

  // pin history for edge detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // straps followed until the first matching address byte
  always_ff @(posedge clk) begin
    if (!resetn) begin
      own_addr <= FIXED_ADDR;
      locked   <= 1'b0;
    end else if (!locked) begin
      own_addr <= strap_addr;
      locked   <= lock_now;
    end
  end

  // alert pin, active low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= !alert_req;
    end
  end

  // idle-bus watchdog
  // holds at its limit, so enabling the release later still frees the bus
  always_ff @(posedge clk) begin
    if (!resetn || activity || st == ST_IDLE) begin
      tmo_cnt <= '0;
    end else if (tmo_cnt != TMO_W'(TIMEOUT_CYC - 1)) begin
      tmo_cnt <= tmo_cnt + 1'b1; // saturate: no wrap while release is off
    end
  end

  // byte engine; covers send byte, write byte, receive byte
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st       <= ST_IDLE;
      cnt      <= '0;
      sr       <= '0;
      tx       <= '0;
      pos      <= POS_ADDR;
      is_read  <= 1'b0;
      rd_index <= PTR_RESET;
      sda_oe   <= 1'b0;
      scl_oe   <= 1'b0;
    end else if (stop_det || tmo_hit) begin
      st     <= ST_IDLE;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (start_det) begin
      st     <= ST_RECV;
      cnt    <= '0;
      pos    <= POS_ADDR;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      unique case (st)
        ST_IDLE, ST_WAIT: begin
          sda_oe <= 1'b0;
        end
        ST_RECV: begin
          if (scl_rise && cnt != BITS_PER_BYTE) begin
            sr  <= {sr[6:0], sda_in};
            cnt <= cnt + 1'b1;
          end else if (byte_end) begin
            unique case (pos)
              POS_ADDR: begin
                if (addr_hit || ara_hit) begin
                  st      <= ST_ACK;
                  sda_oe  <= 1'b1;
                  is_read <= sr[0];
                end else begin
                  st <= ST_WAIT;
                end
              end
              POS_PTR: begin
                rd_index <= sr;
                st       <= ST_ACK;
                sda_oe   <= 1'b1;
              end
              POS_DATA: begin
                st     <= f_ready ? ST_ACK : ST_RECV;
                sda_oe <= f_ready;
                scl_oe <= !f_ready; // stretch while the queue is full
              end
              POS_OVER: begin
                st <= ST_WAIT;
              end
            endcase
          end
        end
        ST_ACK: begin
          scl_oe <= 1'b0;
          if (scl_fall) begin
            cnt <= '0;
            pos <= (pos == POS_OVER) ? POS_OVER : pos + 1'b1;
            if (is_read) begin
              st     <= ST_SEND;
              tx     <= ara_hit ? {own_addr, 1'b0} : rd_data;
              sda_oe <= ara_hit ? !own_addr[6] : !rd_data[7];
            end else begin
              st     <= ST_RECV;
              sda_oe <= 1'b0;
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            cnt <= cnt + 1'b1;
            tx  <= {tx[6:0], 1'b0};
            if (cnt == ADDR_LOCK_BIT) begin
              st     <= ST_MACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= !tx[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_fall) begin
            st <= ST_WAIT;
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  // queue of register writes towards the register file
  smbap_fifo #(
    .WIDTH ($bits(smbap_wr_s)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (byte_end && pos == POS_DATA),
    .in_ready  (f_ready),
    .in_data   (push_data),
    .out_valid (f_valid),
    .out_ready (!wr_valid || wr_ready),
    .out_data  (f_data)
  );

  // output register stage of the write path
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_valid <= 1'b0;
      wr_req   <= '0;
    end else if (!wr_valid || wr_ready) begin
      wr_valid <= f_valid;
      wr_req   <= f_data;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_FIXED_ADDR: assert property (
    !locked && address_select_strap |=> own_addr == FIXED_ADDR)
    else $error("fixed address not selected");
  AST_PICK_ADDR: assert property (
    !locked && !address_select_strap
    |=> own_addr == ($past(address_pick_strap) ? STRAP_ADDR1 : STRAP_ADDR0))
    else $error("strapped address wrong");
  AST_LOCK_HOLD: assert property (
    locked |=> $stable(own_addr) && locked)
    else $error("address moved after lock");
  AST_START_SHIFT: assert property (
    start_det |=> st == ST_RECV && cnt == 4'h0 && !sda_oe)
    else $error("start not taken");
  AST_ACK_MATCH: assert property (
    byte_end && pos == POS_ADDR && addr_hit |=> st == ST_ACK && sda_oe
    ##1 (sda_oe && st == ST_ACK) [*1])
    else $error("matching address not acknowledged");
  AST_MISS_QUIET: assert property (
    st == ST_WAIT |-> !sda_oe)
    else $error("unaddressed slave drives data");
  AST_DIR_READ: assert property (
    st == ST_SEND |-> is_read)
    else $error("sending in a write operation");
  AST_SDA_HIGH_STABLE: assert property (
    (st == ST_SEND || st == ST_ACK) && scl_in && scl_q
    && !stop_det && !start_det |=> $stable(sda_oe))
    else $error("data changed while clock high");
  AST_STOP_IDLE: assert property (
    stop_det |=> st == ST_IDLE && !sda_oe && !scl_oe)
    else $error("stop not seen");
  AST_ONE_READ: assert property (
    st == ST_MACK && scl_fall && !stop_det && !start_det
    |=> st == ST_WAIT)
    else $error("more than one read byte");
  AST_PTR_LOAD: assert property (
    byte_end && pos == POS_PTR && !stop_det && !start_det
    |=> rd_index == $past(sr))
    else $error("pointer not loaded");
  AST_PTR_ONLY: assert property (
    push |-> !is_read && locked && pos == POS_DATA)
    else $error("data pushed outside a write data byte");
  AST_TIMEOUT: assert property (
    tmo_hit && st != ST_IDLE |=> st == ST_IDLE && !sda_oe)
    else $error("timeout did not release bus");
  AST_ALERT: assert property (
    alert_req |=> !alert_n)
    else $error("alert not raised");
  AST_STRETCH_DATA: assert property (
    scl_oe |-> st == ST_RECV && pos == POS_DATA)
    else $error("clock held outside a data byte");

  COV_WRITE_BYTE: cover property (push ##[1:200] stop_det);
  COV_PTR_READ: cover property (
    byte_end && pos == POS_PTR ##[1:400] st == ST_SEND);
  COV_ARA: cover property (st == ST_ACK && ara_hit && is_read);
  COV_STRETCH: cover property (scl_oe ##1 scl_oe);
endmodule

// file: dv/smbap_master.sv
// bus master model: makes clock, start, stop and bytes on the wire
// assumes the bench builds wired-and lines; one transfer at a time
module smbap_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl_drv,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus: both lines released high
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // one bus phase held four clocks, changed off the sampling edge
  task automatic ph(input logic c, input logic d);
    scl_drv = c;
    sda_drv = d;
    repeat (4) @(negedge clk);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    ph(scl_drv, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask
  // stop: data low with clock low, then rises while clock high
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // eight bits msb first, data changed only while clock is low
  task automatic bits(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      ph(1'b0, tx[i]);
      ph(1'b1, tx[i]);
      rx[i] = sda;
      ph(1'b0, tx[i]);
    end
  endtask
  // ninth clock with data released, so a read ends in no-ack
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      output logic ack);
    bits(tx, rx);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ack = ~sda;
    ph(1'b0, 1'b1);
  endtask
endmodule

// file: dv/smbap_slave_bench.sv
// self-checking bench for the serial bus slave front end
// assumes the master model and a register array held here
module smbap_slave_bench
  import smbap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, resetn = 1'b0, sel = 1'b1, pick = 1'b0;
  logic       tmo_dis = 1'b0, alert_req = 1'b0, wr_ready = 1'b1;
  logic       scl_oe, sda_oe, alert_n, wr_valid, m_scl, m_sda;
  logic [7:0] rd_index;
  logic [7:0] regs [256];
  logic [6:0] own_addr;
  smbap_wr_s  wr_req;
  wire        scl = m_scl & ~scl_oe;
  wire        sda = m_sda & ~sda_oe;
  int         num_errors = 0, comparisons = 0, nwr = 0, cyc = 0;

  always #4 clk = ~clk;

  smbap_slave #(.TIMEOUT_CYC(200), .DEPTH(8)) uut (
    .clk(clk), .resetn(resetn), .scl_in(scl), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .address_select_strap(sel), .address_pick_strap(pick),
    .bus_timeout_disable(tmo_dis), .alert_req(alert_req),
    .alert_n(alert_n), .rd_index(rd_index), .rd_data(regs[rd_index]),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_req(wr_req),
    .own_addr(own_addr));
  smbap_master m (.clk(clk), .sda(sda), .scl_drv(m_scl), .sda_drv(m_sda));

  // register file: each slot preset to its index xor a5
  initial for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'ha5;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr_valid && wr_ready) begin
      regs[wr_req.index] <= wr_req.data;
      nwr <= nwr + 1;
    end
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic do_reset(input logic s, input logic p);
    @(negedge clk);
    resetn = 1'b0;
    sel = s;
    pick = p;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  // one read operation at the fixed address, ended by no-ack and stop
  task automatic rd_op(input logic [7:0] exp);
    logic [7:0] rx;
    logic       ack;
    m.start();
    m.xfer({FIXED_ADDR, 1'b1}, rx, ack);
    chk(16'(ack), 16'h1);
    m.xfer(8'hff, rx, ack);
    chk(16'(rx), 16'(exp));
    m.stop();
  endtask

  task automatic t_strap();
    logic [7:0] rx;
    logic       ack;
    do_reset(1'b0, 1'b1);
    m.start();
    m.xfer({STRAP_ADDR0, 1'b0}, rx, ack);
    chk(16'(ack), 16'h0);
    m.stop();
    m.start();
    m.xfer({STRAP_ADDR1, 1'b0}, rx, ack);
    chk(16'(ack), 16'h1);
    m.stop();
    pick = 1'b0;
    repeat (4) @(negedge clk);
    chk(16'(own_addr), 16'(STRAP_ADDR1));
  endtask

  task automatic t_read0();
    do_reset(1'b1, 1'b0);
    chk(16'(own_addr), 16'(FIXED_ADDR));
    rd_op(8'ha5);
  endtask

  // write byte with a third byte, register port stalled meanwhile
  task automatic t_write();
    logic [7:0] rx;
    logic       ack;
    int         n0;
    n0 = nwr;
    wr_ready = 1'b0;
    m.start();
    m.xfer({FIXED_ADDR, 1'b0}, rx, ack);
    m.xfer(8'h41, rx, ack);
    chk(16'(rd_index), 16'h41);
    m.xfer(8'h55, rx, ack);
    chk(16'(ack), 16'h1);
    m.xfer(8'h66, rx, ack);
    chk(16'(ack), 16'h0);
    m.stop();
    chk(16'(wr_valid), 16'h1);
    chk(wr_req, 16'h4155);
    wr_ready = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'(nwr - n0), 16'h1);
  endtask

  // pointer-only write, then a read after a repeated start
  task automatic t_ptr();
    logic [7:0] rx;
    logic       ack;
    int         n0;
    n0 = nwr;
    m.start();
    m.xfer({FIXED_ADDR, 1'b0}, rx, ack);
    m.xfer(8'h41, rx, ack);
    chk(16'(ack), 16'h1);
    rd_op(8'h55);
    chk(16'(nwr - n0), 16'h0);
  endtask

  // ten write bytes with the register port stalled: queue fills, clock held
  task automatic t_stretch();
    logic [7:0] rx;
    logic       ack;
    int         n0;
    n0 = nwr;
    wr_ready = 1'b0;
    for (int k = 0; k < 10; k++) begin
      m.start();
      m.xfer({FIXED_ADDR, 1'b0}, rx, ack);
      m.xfer(8'h60 + 8'(k), rx, ack);
      m.bits(8'h90 + 8'(k), rx);
      m.ph(1'b0, 1'b1);
      chk(16'(scl_oe), 16'(k == 9));
      wr_ready = (k == 9);
      m.ph(1'b0, 1'b1);
      m.ph(1'b1, 1'b1);
      chk(16'(sda), 16'h0);
      m.ph(1'b0, 1'b1);
      m.stop();
    end
    repeat (12) @(negedge clk);
    chk(16'(nwr - n0), 16'ha);
    chk(16'(regs[8'h69]), 16'h99);
  endtask

  task automatic t_alert();
    logic [7:0] rx;
    logic       ack;
    alert_req = 1'b1;
    repeat (2) @(negedge clk);
    chk(16'(alert_n), 16'h0);
    m.start();
    m.xfer({ALERT_RESP, 1'b1}, rx, ack);
    m.xfer(8'hff, rx, ack);
    chk(16'(rx), 16'({FIXED_ADDR, 1'b0}));
    m.stop();
    alert_req = 1'b0;
  endtask

  // bus left quiet in the ack slot, idle release on and off
  task automatic t_tmo();
    logic [7:0] rx;
    for (int d = 0; d < 2; d++) begin
      tmo_dis = d[0];
      m.start();
      m.bits({FIXED_ADDR, 1'b0}, rx);
      m.ph(1'b0, 1'b1);
      chk(16'(sda_oe), 16'h1);
      repeat (300) @(negedge clk);
      chk(16'(sda_oe), 16'(d[0]));
      m.ph(1'b1, 1'b1);
      m.ph(1'b0, 1'b1);
      m.stop();
    end
  endtask

  initial begin
    t_strap();
    t_read0();
    t_write();
    t_ptr();
    t_stretch();
    t_alert();
    t_tmo();
    report_and_stop();
  end
endmodule
